// File: wsd_consts.svh
// Register indices, field positions, reset values and counts of the waveform shutdown block
`ifndef WSD_CONSTS_SVH
`define WSD_CONSTS_SVH

// Register indices, byte address is four times the index
`define WSD_IDX_CLK      10'h3bc
`define WSD_IDX_ISM      10'h3bd
`define WSD_IDX_DBR      10'h3be
`define WSD_IDX_DBF      10'h3bf
`define WSD_IDX_CON0     10'h3c0
`define WSD_IDX_CON1     10'h3c1
`define WSD_IDX_AS0      10'h3c2
`define WSD_IDX_AS1      10'h3c3
`define WSD_IDX_STR      10'h3c4
`define WSD_IDX_IRQ_STAT 10'h3c5
`define WSD_IDX_IRQ_CLR  10'h3c6
`define WSD_IDX_IRQ_EN   10'h3c7

// Field positions
`define WSD_CON0_EN      7
`define WSD_CON0_LD      6
`define WSD_CON1_IN      5
`define WSD_AS0_SD       7
`define WSD_AS0_REN      6
`define WSD_AS0_PAIR_BD_SHUTDOWN_LEVEL_HI  5
`define WSD_AS0_PAIR_BD_SHUTDOWN_LEVEL_LO  4
`define WSD_AS0_PAIR_AC_SHUTDOWN_LEVEL_HI  3
`define WSD_AS0_PAIR_AC_SHUTDOWN_LEVEL_LO  2

// Shutdown level codes
`define WSD_LVL_HIGH     2'h3
`define WSD_LVL_LOW      2'h2
`define WSD_LVL_TRI      2'h1
`define WSD_LVL_INACT    2'h0

// Interrupt event bits
`define WSD_EV_TRIP      0
`define WSD_EV_RESTART   1
`define WSD_EV_RELOAD    2
`define WSD_EV_W         3

// Reset values and dead-band counter width
`define WSD_RST_BYTE     8'h00
`define WSD_RST_EV       3'h0
`define WSD_DB_W         6

`endif

// File: wsd_pkg.sv
// Types shared by the waveform shutdown and dead-band block
package wsd_pkg;

  // Output operating modes
  typedef enum logic [2:0] {
    WSD_MODE_ASYNC_STEER = 3'h0,
    WSD_MODE_SYNC_STEER  = 3'h1,
    WSD_MODE_FWD_BRIDGE  = 3'h2,
    WSD_MODE_REV_BRIDGE  = 3'h3,
    WSD_MODE_HALF_BRIDGE = 3'h4,
    WSD_MODE_PUSH_PULL   = 3'h5,
    WSD_MODE_RSVD6       = 3'h6,
    WSD_MODE_RSVD7       = 3'h7
  } wsd_mode_t;

  // Bus slave phases
  typedef enum logic {WSD_BUS_IDLE, WSD_BUS_ACK} wsd_bus_t;

endpackage

// File: wsd_waveform_shutdown.sv
// Complementary waveform generator: shutdown, dead band, steering and register map
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps
`include "wsd_consts.svh"

module wsd_waveform_shutdown
  import wsd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [15:0] waveform_sources,
  input  wire logic        fast_internal_osc,
  input  wire logic        routed_input_pin,
  input  wire logic        timer_two_post_out,
  input  wire logic        timer_four_post_out,
  input  wire logic        comparator_one_out,
  input  wire logic        comparator_two_out,
  input  wire logic        logic_cell_two_out,
  input  wire logic        logic_cell_four_out,
  output logic             output_a,
  output logic             output_b,
  output logic             output_c,
  output logic             output_d,
  output logic             output_a_oe,
  output logic             output_b_oe,
  output logic             output_c_oe,
  output logic             output_d_oe,
  output logic             irq
);

  // Register file
  logic                  clk_sel_r;
  logic [3:0]            waveform_source_choice_r;
  logic [`WSD_DB_W-1:0]  rise_delay_count_r;
  logic [`WSD_DB_W-1:0]  fall_delay_count_r;
  logic                  enable_r;
  logic                  delay_reload_request_r;
  wsd_mode_t             mode_r;
  logic [3:0]            output_invert_r;
  logic                  shutdown_r;
  logic                  restart_en_r;
  logic [1:0]            pair_bd_shutdown_level_r;
  logic [1:0]            pair_ac_shutdown_level_r;
  logic [7:0]            shutdown_source_on_r;
  logic [3:0]            steer_override_level_r;
  logic [3:0]            steer_select_r;
  logic [`WSD_EV_W-1:0]  irq_stat_r;
  logic [`WSD_EV_W-1:0]  irq_en_r;

  // Bus and datapath state
  wsd_bus_t              bus_r;
  logic [31:0]           readdata_r;
  logic                  data_r;
  logic                  out_hold_r;
  logic                  reload_armed_r;
  logic                  push_phase_r;
  logic [3:0]            steer_act_r;
  logic [`WSD_DB_W-1:0]  rise_act_r;
  logic [`WSD_DB_W-1:0]  fall_act_r;
  logic [`WSD_DB_W-1:0]  edge_cnt_r;
  logic [`WSD_DB_W-1:0]  sd_cnt_r;
  logic [3:0]            out_r;
  logic [3:0]            oe_r;
  logic                  irq_r;

  // Combinational terms
  logic                  data_in;
  logic                  rise_edge;
  logic                  fall_edge;
  logic                  gen_tick;
  logic [7:0]            src_vec;
  logic                  trip;
  logic                  a_db;
  logic                  b_db;
  logic [3:0]            wave;
  logic [3:0]            pol_used;
  logic [3:0]            out_nxt;
  logic [3:0]            oe_nxt;
  logic [`WSD_EV_W-1:0]  events;
  logic [9:0]            reg_idx;
  logic                  wr_acc;
  logic                  rd_acc;
  logic [7:0]            wbyte;
  logic [7:0]            rbyte;

  // Bus decode
  assign reg_idx = avs_address[11:2];
  assign rd_acc  = avs_read && (bus_r == WSD_BUS_IDLE);
  assign wr_acc  = avs_write && (bus_r == WSD_BUS_ACK) && avs_byteenable[0];
  assign wbyte   = avs_writedata[7:0];

  // Data input selection and edge detect
  assign data_in   = waveform_sources[waveform_source_choice_r];
  assign rise_edge = data_in && !data_r;
  assign fall_edge = !data_in && data_r;
  assign gen_tick  = clk_sel_r ? fast_internal_osc : 1'b1;

  assign src_vec = {1'b0, logic_cell_four_out, logic_cell_two_out, comparator_two_out,
                    comparator_one_out, timer_four_post_out, timer_two_post_out,
                    routed_input_pin};
  assign trip = |(src_vec & shutdown_source_on_r);

  // rising dead band, falling dead band, zero count passes at once
  assign a_db = data_r && (edge_cnt_r >= rise_act_r);
  assign b_db = !data_r && (edge_cnt_r >= fall_act_r);

  // Event pulses for interrupt status
  assign events[`WSD_EV_TRIP]    = enable_r && trip && !shutdown_r;
  assign events[`WSD_EV_RESTART] = out_hold_r && !shutdown_r && rise_edge;
  assign events[`WSD_EV_RELOAD]  = reload_armed_r && rise_edge;

  // Read mux
  always_comb begin
    case (reg_idx)
      `WSD_IDX_CLK:      rbyte = {7'h00, clk_sel_r};
      `WSD_IDX_ISM:      rbyte = {4'h0, waveform_source_choice_r};
      `WSD_IDX_DBR:      rbyte = {2'h0, rise_delay_count_r};
      `WSD_IDX_DBF:      rbyte = {2'h0, fall_delay_count_r};
      `WSD_IDX_CON0:     rbyte = {enable_r, delay_reload_request_r, 3'h0, mode_r};
      `WSD_IDX_CON1:     rbyte = {2'h0, data_r, 1'b0, output_invert_r};
      `WSD_IDX_AS0:      rbyte = {shutdown_r, restart_en_r, pair_bd_shutdown_level_r,
                                  pair_ac_shutdown_level_r, 2'h0};
      `WSD_IDX_AS1:      rbyte = shutdown_source_on_r;
      `WSD_IDX_STR:      rbyte = {steer_override_level_r, steer_select_r};
      `WSD_IDX_IRQ_STAT: rbyte = {5'h00, irq_stat_r};
      `WSD_IDX_IRQ_EN:   rbyte = {5'h00, irq_en_r};
      default:           rbyte = 8'h00;
    endcase
  end

  // Wait state: one cycle, then acknowledge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_r      <= WSD_BUS_IDLE;
      readdata_r <= 32'h0000_0000;
    end else begin
      case (bus_r)
        WSD_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_r <= WSD_BUS_ACK;
          end
          readdata_r <= rd_acc ? {24'h00_0000, rbyte} : 32'h0000_0000;
        end
        WSD_BUS_ACK: begin
          bus_r      <= WSD_BUS_IDLE;
          readdata_r <= 32'h0000_0000;
        end
        default: bus_r <= WSD_BUS_IDLE;
      endcase
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_sel_r                <= 1'b0;
      waveform_source_choice_r <= 4'h0;
      enable_r                 <= 1'b0;
      mode_r                   <= WSD_MODE_ASYNC_STEER;
      output_invert_r          <= 4'h0;
      restart_en_r             <= 1'b0;
      pair_bd_shutdown_level_r <= 2'h0;
      pair_ac_shutdown_level_r <= 2'h0;
      shutdown_source_on_r     <= `WSD_RST_BYTE;
      steer_override_level_r   <= 4'h0;
      steer_select_r           <= 4'h0;
      irq_en_r                 <= `WSD_RST_EV;
    end else if (wr_acc) begin
      case (reg_idx)
        `WSD_IDX_CLK: clk_sel_r <= wbyte[0];
        `WSD_IDX_ISM: waveform_source_choice_r <= wbyte[3:0];
        `WSD_IDX_CON0: begin
          enable_r <= wbyte[`WSD_CON0_EN];
          mode_r   <= wsd_mode_t'(wbyte[2:0]);
        end
        `WSD_IDX_CON1: output_invert_r <= wbyte[3:0];
        `WSD_IDX_AS0: begin
          restart_en_r             <= wbyte[`WSD_AS0_REN];
          pair_bd_shutdown_level_r <= wbyte[`WSD_AS0_PAIR_BD_SHUTDOWN_LEVEL_HI:`WSD_AS0_PAIR_BD_SHUTDOWN_LEVEL_LO];
          pair_ac_shutdown_level_r <= wbyte[`WSD_AS0_PAIR_AC_SHUTDOWN_LEVEL_HI:`WSD_AS0_PAIR_AC_SHUTDOWN_LEVEL_LO];
        end
        // source enables writable in any state
        `WSD_IDX_AS1: shutdown_source_on_r <= wbyte;
        `WSD_IDX_STR: begin
          steer_override_level_r <= wbyte[7:4];
          steer_select_r         <= wbyte[3:0];
        end
        `WSD_IDX_IRQ_EN: irq_en_r <= wbyte[`WSD_EV_W-1:0];
        default: ;
      endcase
    end
  end

  // dead-band counts keep contents through reset
  always_ff @(posedge clk) begin
    if (wr_acc && reg_idx == `WSD_IDX_DBR) begin
      rise_delay_count_r <= wbyte[`WSD_DB_W-1:0];
    end
    if (wr_acc && reg_idx == `WSD_IDX_DBF) begin
      fall_delay_count_r <= wbyte[`WSD_DB_W-1:0];
    end
  end

  // load request: set by software, cleared on reload
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      delay_reload_request_r <= 1'b0;
      reload_armed_r         <= 1'b0;
    end else begin
      if (!delay_reload_request_r) begin
        reload_armed_r <= 1'b0;
      end else if (fall_edge) begin
        reload_armed_r <= 1'b1;
      end else if (rise_edge && reload_armed_r) begin
        reload_armed_r <= 1'b0;
      end
      // Set wins over the hardware clear; needs enable already on
      if (wr_acc && reg_idx == `WSD_IDX_CON0 && wbyte[`WSD_CON0_LD] && enable_r) begin
        delay_reload_request_r <= 1'b1;
      end else if (!enable_r || (reload_armed_r && rise_edge)) begin
        delay_reload_request_r <= 1'b0;
      end
    end
  end

  // Active dead-band buffers, follow registers while disabled
  always_ff @(posedge clk) begin
    if (!enable_r || (reload_armed_r && rise_edge)) begin
      rise_act_r <= rise_delay_count_r;
      fall_act_r <= fall_delay_count_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shutdown_r <= 1'b0;
    end else if (enable_r && trip) begin
      // enabled source wins over any clear
      shutdown_r <= 1'b1;
    end else if (wr_acc && reg_idx == `WSD_IDX_AS0) begin
      // software may force or clear shutdown
      shutdown_r <= wbyte[`WSD_AS0_SD];
    end else if (restart_en_r) begin
      shutdown_r <= 1'b0;
    end
  end

  // outputs stay shut until a rising data edge after clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_hold_r <= 1'b1;
    end else if (shutdown_r) begin
      out_hold_r <= 1'b1;
    end else if (rise_edge) begin
      out_hold_r <= 1'b0;
    end
  end

  // Data sample, dead-band counter, push-pull phase, steering buffer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_r       <= 1'b0;
      edge_cnt_r   <= 6'h00;
      push_phase_r <= 1'b0;
      steer_act_r  <= 4'h0;
    end else begin
      data_r <= data_in;
      if (rise_edge || fall_edge) begin
        edge_cnt_r <= 6'h00;
      end else if (gen_tick && edge_cnt_r != 6'h3f) begin
        edge_cnt_r <= edge_cnt_r + 6'h01;
      end
      if (rise_edge) begin
        push_phase_r <= !push_phase_r;
      end
      // Synchronous steering changes only on a rising edge
      if (mode_r != WSD_MODE_SYNC_STEER || rise_edge) begin
        steer_act_r <= steer_select_r;
      end
    end
  end

  // time since shutdown entry, for the inactive-level delay
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sd_cnt_r <= 6'h00;
    end else if (!out_hold_r) begin
      sd_cnt_r <= 6'h00;
    end else if (gen_tick && sd_cnt_r != 6'h3f) begin
      sd_cnt_r <= sd_cnt_r + 6'h01;
    end
  end

  // mode decode, steering with polarity or override
  always_comb begin
    wave     = 4'h0;
    pol_used = output_invert_r;
    case (mode_r)
      WSD_MODE_ASYNC_STEER, WSD_MODE_SYNC_STEER: begin
        for (int i = 0; i < 4; i++) begin
          wave[i]     = steer_act_r[i] ? data_r : steer_override_level_r[i];
          pol_used[i] = steer_act_r[i] && output_invert_r[i];
        end
      end
      WSD_MODE_FWD_BRIDGE: wave = {data_r, 1'b0, 1'b0, 1'b1};
      WSD_MODE_REV_BRIDGE: wave = {1'b0, 1'b1, data_r, 1'b0};
      WSD_MODE_HALF_BRIDGE: wave = {b_db, a_db, b_db, a_db};
      WSD_MODE_PUSH_PULL: begin
        wave = {data_r && !push_phase_r, data_r && push_phase_r,
                data_r && !push_phase_r, data_r && push_phase_r};
      end
      default: wave = 4'h0;
    endcase
  end

  // Final pin levels, shutdown override per pair
  always_comb begin
    out_nxt = wave ^ pol_used;
    oe_nxt  = 4'hf;
    if (!enable_r && !out_hold_r) begin
      out_nxt = output_invert_r;
    end else if (out_hold_r) begin
      for (int i = 0; i < 4; i++) begin
        // A/C use bits 3:2, B/D use bits 5:4
        case ((i % 2 == 0) ? pair_ac_shutdown_level_r : pair_bd_shutdown_level_r)
          `WSD_LVL_HIGH: out_nxt[i] = 1'b1;
          `WSD_LVL_LOW:  out_nxt[i] = 1'b0;
          `WSD_LVL_TRI: begin
            out_nxt[i] = 1'b0;
            oe_nxt[i]  = 1'b0;
          end
          default: begin
            // inactive with polarity once dead band passed
            if (sd_cnt_r >= ((i % 2 == 0) ? fall_act_r : rise_act_r)) begin
              out_nxt[i] = output_invert_r[i];
            end
          end
        endcase
      end
    end
  end

  // Registered pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_r <= 4'h0;
      oe_r  <= 4'h0;
    end else begin
      out_r <= out_nxt;
      oe_r  <= oe_nxt;
    end
  end

  // Sticky interrupt status, set wins over write-one clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_r <= `WSD_RST_EV;
      irq_r      <= 1'b0;
    end else begin
      if (wr_acc && reg_idx == `WSD_IDX_IRQ_CLR) begin
        irq_stat_r <= (irq_stat_r & ~wbyte[`WSD_EV_W-1:0]) | events;
      end else begin
        irq_stat_r <= irq_stat_r | events;
      end
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end

  assign avs_readdata    = readdata_r;
  assign avs_waitrequest = (bus_r == WSD_BUS_IDLE);
  assign output_a        = out_r[0];
  assign output_b        = out_r[1];
  assign output_c        = out_r[2];
  assign output_d        = out_r[3];
  assign output_a_oe     = oe_r[0];
  assign output_b_oe     = oe_r[1];
  assign output_c_oe     = oe_r[2];
  assign output_d_oe     = oe_r[3];
  assign irq             = irq_r;

endmodule // wsd_waveform_shutdown

// File: wsd_pad_model.sv
// Pad stage seen by the power drivers on the four outputs
`timescale 1ns/100ps
module wsd_pad_model (
  input  wire logic       clk,
  input  wire logic [3:0] pin,
  input  wire logic [3:0] oe,
  output logic      [3:0] pad
);
  logic [3:0] last_r;

  // Last level seen on each pad
  always_ff @(posedge clk) begin
    last_r <= pad;
  end

  // released pad
  // Undriven pad shows the inverse of its last level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pad[i] = oe[i] ? pin[i] : ~last_r[i];
    end
  end
endmodule // wsd_pad_model

// File: wsd_chk_asserts.sv
// Port assertions of the waveform shutdown block
`timescale 1ns/100ps
`include "wsd_consts.svh"
module wsd_chk_asserts (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        routed_input_pin,
  input wire logic        timer_two_post_out,
  input wire logic        timer_four_post_out,
  input wire logic        comparator_one_out,
  input wire logic        comparator_two_out,
  input wire logic        logic_cell_two_out,
  input wire logic        logic_cell_four_out,
  input wire logic        output_a,
  input wire logic        output_b,
  input wire logic        output_c,
  input wire logic        output_d,
  input wire logic        output_a_oe,
  input wire logic        output_b_oe,
  input wire logic        output_c_oe,
  input wire logic        output_d_oe
);
  logic [3:0] lvl_r;
  logic [6:0] src_en_r;
  logic       run_r;
  logic       wr_ok;
  logic       trip;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Accepted write and enabled active source
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign trip  = run_r && |(src_en_r & {logic_cell_four_out, logic_cell_two_out,
                 comparator_two_out, comparator_one_out, timer_four_post_out,
                 timer_two_post_out, routed_input_pin});

  // Mirror of the software shutdown settings
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lvl_r    <= 4'h0;
      src_en_r <= 7'h00;
      run_r    <= 1'b0;
    end else if (wr_ok) begin
      if (avs_address[11:2] == `WSD_IDX_AS0) lvl_r <= avs_writedata[5:2];
      if (avs_address[11:2] == `WSD_IDX_AS1) src_en_r <= avs_writedata[6:0];
      if (avs_address[11:2] == `WSD_IDX_CON0) run_r <= avs_writedata[7];
    end
  end

  // Pin pair matches its shutdown code
  function automatic logic lvl_ok(logic [1:0] c, logic p0, logic p1, logic e0, logic e1);
    case (c)
      2'h3: lvl_ok = p0 && p1 && e0 && e1;
      2'h2: lvl_ok = !p0 && !p1 && e0 && e1;
      2'h1: lvl_ok = !e0 && !e1;
      default: lvl_ok = 1'b1;
    endcase
  endfunction

  chk_bus_one_wait:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Request not answered after one wait cycle");
  chk_ack_single:
    assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("Answer held longer than one cycle");
  chk_idle_rdata:
    assert property (avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("Read data not zero outside answer");
  chk_upper_zero:
    assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("Upper read data bits not zero");
  chk_ac_oe_pair:
    assert property (output_a_oe == output_c_oe)
    else $error("A and C enables differ");
  chk_bd_oe_pair:
    assert property (output_b_oe == output_d_oe)
    else $error("B and D enables differ");
  chk_ac_trip_level:
    assert property (trip |-> ##3 lvl_ok(lvl_r[1:0], output_a, output_c, output_a_oe, output_c_oe))
    else $error("A and C not at shutdown level after trip");
  chk_bd_trip_level:
    assert property (trip |-> ##3 lvl_ok(lvl_r[3:2], output_b, output_d, output_b_oe, output_d_oe))
    else $error("B and D not at shutdown level after trip");
endmodule // wsd_chk_asserts

bind wsd_waveform_shutdown wsd_chk_asserts i_chk (
  .clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .routed_input_pin, .timer_two_post_out,
  .timer_four_post_out, .comparator_one_out, .comparator_two_out, .logic_cell_two_out,
  .logic_cell_four_out, .output_a, .output_b, .output_c, .output_d, .output_a_oe,
  .output_b_oe, .output_c_oe, .output_d_oe
);

// File: tb_top.sv
// Self-checking bench of the waveform shutdown block
`timescale 1ns/100ps
`include "wsd_consts.svh"
module tb_top;
  typedef struct packed {
    logic [9:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } wsd_row_t;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        data = 1'b0;
  logic [6:0]  sd = 7'h00;
  logic [3:0]  pins;
  logic [3:0]  oe_v;
  logic [3:0]  pad;
  logic        irq;
  int          err_count = 0;
  int          num_checks = 0;
  wsd_row_t    rows [12] = '{'{`WSD_IDX_CLK, 8'hff, 8'h01}, '{`WSD_IDX_ISM, 8'hff, 8'h0f},
    '{`WSD_IDX_DBR, 8'hff, 8'h3f}, '{`WSD_IDX_DBF, 8'hea, 8'h2a}, '{`WSD_IDX_STR, 8'ha5, 8'ha5},
    '{`WSD_IDX_AS1, 8'hff, 8'hff}, '{`WSD_IDX_AS0, 8'hbc, 8'hbc}, '{`WSD_IDX_IRQ_EN, 8'hff, 8'h07},
    '{10'h3c8, 8'h55, 8'h00}, '{`WSD_IDX_CLK, 8'h00, 8'h00}, '{`WSD_IDX_ISM, 8'h00, 8'h00},
    '{`WSD_IDX_IRQ_EN, 8'h00, 8'h00}};
  logic [7:0]  rise_n [3] = '{8'h00, 8'h01, 8'h07};
  logic [7:0]  fall_n [3] = '{8'h00, 8'h06, 8'h02};
  logic [3:0]  mode_pins [8] = '{4'h7, 4'h7, 4'h9, 4'h6, 4'h5, 4'h0, 4'h0, 4'h0};

  wsd_waveform_shutdown i_dut (
    .clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .waveform_sources({15'h0000, data}), .fast_internal_osc(1'b1),
    .routed_input_pin(sd[0]), .timer_two_post_out(sd[1]), .timer_four_post_out(sd[2]),
    .comparator_one_out(sd[3]), .comparator_two_out(sd[4]), .logic_cell_two_out(sd[5]),
    .logic_cell_four_out(sd[6]), .output_a(pins[0]), .output_b(pins[1]), .output_c(pins[2]),
    .output_d(pins[3]), .output_a_oe(oe_v[0]), .output_b_oe(oe_v[1]), .output_c_oe(oe_v[2]),
    .output_d_oe(oe_v[3]), .irq
  );
  wsd_pad_model i_pad (.clk, .pin(pins), .oe(oe_v), .pad);

  // Free-running clock
  initial begin
    forever #4 clk = ~clk;
  end

  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp4(input string nm, input logic [3:0] e, input logic [3:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One bus cycle, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d,
                     output logic [7:0] r);
    @(posedge clk);
    avs_address <= {i, 2'h0};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, i, d, r);
  endtask

  task automatic rdc(input logic [9:0] i, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] r;
    bus(1'b0, i, 8'h00, r);
    cmp8($sformatf("reg %h", i), e, r & m);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // Edges from data change until pin A or B rises
  task automatic meas(input logic ch, input int n);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (pins[ch] !== 1'b1 && k < 90);
    cmp4("dead band", 4'h1, {3'h0, k >= n + 2 && k <= n + 3});
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (7) @(posedge clk);
    @(negedge clk);
    cmp4("reset oe", 4'h0, oe_v);
    @(posedge clk) reset_n <= 1'b1;
    for (int i = 10'h3bc; i < 10'h3c8; i++)
      if (i != 10'h3be && i != 10'h3bf && i != 10'h3c6)
        rdc(10'(i), 8'h00, (i == 10'h3c1) ? 8'h0f : 8'hff);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rdc(rows[i].idx, rows[i].exp, 8'hff);
    end
    wr(`WSD_IDX_AS1, 8'h00);
    wt(3);
    cmp4("soft pads", 4'hf, pad);
    cmp4("soft oe", 4'hf, oe_v);
    wr(`WSD_IDX_AS0, 8'h00);
    $display("test registers done");
    for (int j = 0; j < 3; j++) begin
      wr(`WSD_IDX_CON0, 8'h04);
      wr(`WSD_IDX_DBR, rise_n[j]);
      wr(`WSD_IDX_DBF, fall_n[j]);
      wr(`WSD_IDX_CON0, 8'h84);
      @(posedge clk) data <= 1'b1;
      wt(12);
      @(posedge clk) data <= 1'b0;
      wt(12);
      @(posedge clk) data <= 1'b1;
      meas(1'b0, rise_n[j]);
      wt(12);
      @(posedge clk) data <= 1'b0;
      meas(1'b1, fall_n[j]);
    end
    wr(`WSD_IDX_DBR, 8'h02);
    wr(`WSD_IDX_CON0, 8'hc4);
    @(posedge clk) data <= 1'b1;
    meas(1'b0, 7);
    for (int j = 0; j < 2; j++) begin
      wt(12);
      @(posedge clk) data <= ~data;
    end
    meas(1'b0, 2);
    rdc(`WSD_IDX_CON0, 8'h84, 8'hff);
    $display("test dead band done");
    @(posedge clk) data <= 1'b0;
    wr(`WSD_IDX_AS0, 8'h34);
    for (int s = 0; s < 7; s++) begin
      wr(`WSD_IDX_AS1, 8'h00);
      wr(`WSD_IDX_IRQ_EN, (s != 0) ? 8'h01 : 8'h00);
      @(posedge clk) sd <= 7'h01 << s;
      wt(4);
      rdc(`WSD_IDX_AS0, 8'h34, 8'hff);
      wr(`WSD_IDX_AS1, 8'h01 << s);
      wt(4);
      cmp4("trip oe", 4'ha, oe_v);
      cmp4("trip pads", 4'ha, pad & 4'ha);
      cmp4("irq", {3'h0, s != 0}, {3'h0, irq});
      rdc(`WSD_IDX_AS0, 8'hb4, 8'hff);
      rdc(`WSD_IDX_IRQ_STAT, 8'h01, 8'h01);
      @(posedge clk) sd <= 7'h00;
      rdc(`WSD_IDX_AS0, 8'hb4, 8'hff);
      wr(`WSD_IDX_AS0, 8'h34);
      wt(6);
      cmp4("hold oe", 4'ha, oe_v);
      @(posedge clk) data <= 1'b1;
      wt(4);
      cmp4("run oe", 4'hf, oe_v);
      @(posedge clk) data <= 1'b0;
      wr(`WSD_IDX_IRQ_CLR, 8'h07);
      wt(2);
      cmp4("irq clear", 4'h0, {3'h0, irq});
    end
    $display("test shutdown done");
    wr(`WSD_IDX_CON1, 8'h0f);
    wr(`WSD_IDX_AS0, 8'h40);
    wr(`WSD_IDX_AS1, 8'h08);
    @(posedge clk) sd <= 7'h08;
    wt(12);
    cmp4("inactive", 4'hf, pad & oe_v);
    @(posedge clk) sd <= 7'h00;
    wt(4);
    rdc(`WSD_IDX_AS0, 8'h40, 8'hff);
    cmp4("restart hold", 4'hf, pad & oe_v);
    @(posedge clk) data <= 1'b1;
    wt(12);
    cmp4("restart run", 4'ha, pad);
    $display("test restart done");
    wr(`WSD_IDX_CON1, 8'h00);
    wr(`WSD_IDX_STR, 8'h43);
    for (int m = 0; m < 8; m++) begin
      wr(`WSD_IDX_CON0, {5'h10, 3'(m)});
      @(posedge clk) data <= 1'b0;
      wt(8);
      @(posedge clk) data <= 1'b1;
      wt(12);
      if (m == 5) cmp4("push pull", 4'h1, {3'h0, pad[0] ^ pad[1]});
      else cmp4("mode pins", mode_pins[m], pad);
    end
    $display("test modes done");
    wr(`WSD_IDX_DBR, 8'h15);
    @(posedge clk) reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rdc(`WSD_IDX_DBR, 8'h15, 8'hff);
    rdc(`WSD_IDX_CON0, 8'h00, 8'hff);
    $display("test second reset done");
    give_verdict();
  end
endmodule // tb_top
